// ===== src/ucr_pkg.sv
// ucr_pkg: constants and carriers of the character responder
// assumes one 100 MHz clock and a synchronous active-high reset
// ======================================================================
// Summary of operation
// - every character carries exactly eight data bits.
// - data bits go onto and come off the line least significant bit first.
// - an even parity bit follows the data and the receiver checks it.
// - both lines run at 9600 bit/s derived from the system clock.
// - the received line is taken at normal polarity, not inverted.
// - a clean 0x54 is answered with 0x4F 0x4B 0x0D 0x0A.
// - a clean 0x74 is answered with 0x6F 0x6B 0x0D 0x0A.
// - any other clean byte is answered with 0x55 0x43 0x0D 0x0A.
// - a parity failure is answered with 0x50 0x45 0x0D 0x0A.
// - a bad stop bit is answered with 0x46 0x45 0x0D 0x0A.
// - a character arriving before the last was taken is answered with 0x4F 0x45 0x0D 0x0A.
// - separate receive-done, transmit-done and receive-error events are raised.
// - receive events are served ahead of the transmit-done event.
// - the block waits for a receive event and returns to waiting after the reply.
// - one channel transmits on the output line and one receives on the input line.
package ucr_pkg;
   // ===================================================================
   // timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BAUD_BPS = 9600;
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
   localparam int unsigned DATA_BITS = 8;
   localparam logic [3:0] FRAME_LAST = 4'hA; // start, 8 data, parity, stop -> index 10
   // ===================================================================
   // received and answer codes
   localparam logic [7:0] CH_UP_T = 8'h54;
   localparam logic [7:0] CH_LO_T = 8'h74;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_UP_O = 8'h4F;
   localparam logic [7:0] CH_UP_K = 8'h4B;
   localparam logic [7:0] CH_LO_O = 8'h6F;
   localparam logic [7:0] CH_LO_K = 8'h6B;
   localparam logic [7:0] CH_UP_U = 8'h55;
   localparam logic [7:0] CH_UP_C = 8'h43;
   localparam logic [7:0] CH_UP_P = 8'h50;
   localparam logic [7:0] CH_UP_E = 8'h45;
   localparam logic [7:0] CH_UP_F = 8'h46;

   typedef enum logic [1:0] {
      UCR_WAIT = 2'b00,
      UCR_SEND = 2'b01,
      UCR_GAP = 2'b10
   } ucr_mode_t;

   // events visible at the ports
   typedef struct packed {
      logic rx_done;
      logic tx_done;
      logic rx_error;
   } ucr_evt_t;

   // error classes of a finished reception
   typedef struct packed {
      logic parity;
      logic framing;
      logic overrun;
   } ucr_err_t;
endpackage : ucr_pkg

// ===== src/ucr_responder.sv
// ucr_responder: receives one character and answers with a four-byte reply
// assumes serial_in_line synchronous to clk_i; lines idle high
`timescale 1ns/1ps
module ucr_responder #(
   parameter int unsigned BIT_CYC = ucr_pkg::BIT_CYCLES // cycles per bit
) (
   input wire logic clk_i, // 100 MHz clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic serial_in_line_i, // receive line
   output logic serial_out_line_o, // transmit line
   output ucr_pkg::ucr_evt_t events_o, // one-cycle event pulses
   output ucr_pkg::ucr_err_t last_err_o, // error class of the last received character, cleared by a clean one
   output logic busy_o // high while a reply is pending
);
   import ucr_pkg::*;

   // ===================================================================
   // state
   typedef struct packed {
      logic [15:0] rx_cnt;
      logic [3:0] rx_idx;
      logic rx_act;
      logic [7:0] rx_sh;
      logic rx_par;
      logic [15:0] tx_cnt;
      logic [3:0] tx_idx;
      logic tx_act;
      logic [10:0] tx_sh;
      logic [1:0] byte_no;
      logic [7:0] m0;
      logic [7:0] m1;
      logic [7:0] cur0; // first byte of the reply now on the line
      logic [7:0] cur1; // second byte of the reply now on the line
      ucr_mode_t mode;
      logic pend;
      logic line;
      ucr_evt_t evt;
      ucr_err_t err;
      logic busy;
   } ucr_state_t;

   ucr_state_t st;
   ucr_state_t next_st;

   localparam logic [15:0] BIT_C = 16'(BIT_CYC - 1);
   localparam logic [15:0] HALF_C = 16'(BIT_CYC / 2 - 1);

   // frame a byte: stop, parity, data lsb first, start in bit 0
   function automatic logic [10:0] frame(input logic [7:0] d);
      frame = {1'b1, ^d, d, 1'b0};
   endfunction : frame

   // ===================================================================
   // next state
   always_comb begin
      logic [7:0] b;
      logic rx_end;
      logic tx_end;
      b = 8'h00;
      rx_end = 1'b0;
      tx_end = 1'b0;
      next_st = st;
      next_st.evt = '0;
      // receive channel, line used at normal polarity
      if (!st.rx_act) begin
         if (!serial_in_line_i) begin
            next_st.rx_act = 1'b1;
            next_st.rx_cnt = HALF_C;
            next_st.rx_idx = 4'h0;
         end
      end else if (st.rx_cnt != 16'h0000) begin
         next_st.rx_cnt = st.rx_cnt - 16'h0001;
      end else begin
         next_st.rx_cnt = BIT_C;
         next_st.rx_idx = st.rx_idx + 4'h1;
         // mid-bit samples: start, eight data bits, parity, then stop
         if (st.rx_idx == 4'h0) begin
            if (serial_in_line_i) begin
               next_st.rx_act = 1'b0; // glitch, not a start bit
            end
         end else if (st.rx_idx <= 4'(DATA_BITS)) begin
            next_st.rx_sh = {serial_in_line_i, st.rx_sh[7:1]};
         end else if (st.rx_idx == 4'(DATA_BITS + 1)) begin
            next_st.rx_par = serial_in_line_i;
         end else begin
            rx_end = 1'b1;
            next_st.rx_act = 1'b0;
         end
      end
      // receive completion served ahead of the transmitter
      if (rx_end) begin
         next_st.err.parity = (^st.rx_sh) != st.rx_par;
         next_st.err.framing = !serial_in_line_i;
         next_st.err.overrun = st.pend;
         // reply choice: overrun, then framing, then parity, then the data itself
         if (st.pend) begin
            next_st.m0 = CH_UP_O;
            next_st.m1 = CH_UP_E;
         end else if (!serial_in_line_i) begin
            next_st.m0 = CH_UP_F;
            next_st.m1 = CH_UP_E;
         end else if ((^st.rx_sh) != st.rx_par) begin
            next_st.m0 = CH_UP_P;
            next_st.m1 = CH_UP_E;
         end else if (st.rx_sh == CH_UP_T) begin
            next_st.m0 = CH_UP_O;
            next_st.m1 = CH_UP_K;
         end else if (st.rx_sh == CH_LO_T) begin
            next_st.m0 = CH_LO_O;
            next_st.m1 = CH_LO_K;
         end else begin
            next_st.m0 = CH_UP_U;
            next_st.m1 = CH_UP_C;
         end
         // one event per character, error or done, never both
         if (st.pend || !serial_in_line_i || ((^st.rx_sh) != st.rx_par)) begin
            next_st.evt.rx_error = 1'b1;
         end else begin
            next_st.evt.rx_done = 1'b1;
         end
         // a reply is now owed; another character before it starts is an overrun
         next_st.pend = 1'b1;
      end
      // transmit channel
      if (st.tx_act) begin
         if (st.tx_cnt != 16'h0000) begin
            next_st.tx_cnt = st.tx_cnt - 16'h0001;
         end else begin
            next_st.tx_cnt = BIT_C;
            next_st.line = st.tx_sh[0];
            next_st.tx_sh = {1'b1, st.tx_sh[10:1]};
            next_st.tx_idx = st.tx_idx + 4'h1;
            if (st.tx_idx == FRAME_LAST + 4'h1) begin
               next_st.tx_act = 1'b0;
               next_st.line = 1'b1;
               tx_end = 1'b1;
            end
         end
      end
      if (tx_end) begin
         next_st.evt.tx_done = 1'b1;
      end
      // reply sequencer
      unique case (st.mode)
         UCR_WAIT: begin
            if (st.pend && !rx_end) begin
               next_st.pend = 1'b0;
               next_st.busy = 1'b1;
               // copy the owed bytes, so a character queued during this reply cannot alter it
               next_st.cur0 = st.m0;
               next_st.cur1 = st.m1;
               next_st.byte_no = 2'b00;
               next_st.mode = UCR_SEND;
            end
         end
         UCR_SEND: begin
            unique case (st.byte_no)
               2'b00: b = st.cur0;
               2'b01: b = st.cur1;
               2'b10: b = CH_CR;
               2'b11: b = CH_LF;
            endcase
            next_st.tx_sh = frame(b);
            next_st.tx_idx = 4'h0;
            next_st.tx_cnt = 16'h0000;
            next_st.tx_act = 1'b1;
            next_st.mode = UCR_GAP;
         end
         UCR_GAP: begin
            if (tx_end) begin
               if (st.byte_no == 2'b11) begin
                  // stay busy when another reply is already owed
                  next_st.busy = rx_end || st.pend;
                  next_st.mode = UCR_WAIT;
               end else begin
                  next_st.byte_no = st.byte_no + 2'b01;
                  next_st.mode = UCR_SEND;
               end
            end
         end
         default: next_st.mode = UCR_WAIT;
      endcase
   end

   // ===================================================================
   // register the state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.line <= 1'b1;
         st.mode <= UCR_WAIT;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flip-flops
   assign serial_out_line_o = st.line;
   assign events_o = st.evt;
   assign last_err_o = st.err;
   assign busy_o = st.busy;
endmodule : ucr_responder

// ===== verif/ucr_responder_chk.sv
// ucr_chk: port assertions of the responder
// assumes ucr_pkg compiled first; bound to ucr_responder
`timescale 1ns/1ps
module ucr_chk #(
   parameter int unsigned BIT_CYC = 16 // cycles per bit
) (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic serial_in_line_i, // rx line
   input wire logic serial_out_line_o, // tx line
   input wire ucr_pkg::ucr_evt_t events_o, // events
   input wire ucr_pkg::ucr_err_t last_err_o, // error class
   input wire logic busy_o // busy
);
   import ucr_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   int unsigned low_cnt;
   // =========================================
   // length of the current low stretch on tx
   always_ff @(posedge clk_i) begin
      low_cnt <= (rst_i || serial_out_line_o) ? 0 : low_cnt + 1;
   end
   rst_idle_a: assert property ($fell(rst_i) |-> serial_out_line_o && events_o == '0 && !busy_o)
      else $error("not idle after reset");
   rx_pulse_a: assert property (events_o.rx_done |=> !events_o.rx_done)
      else $error("rx event longer than a cycle");
   tx_pulse_a: assert property (events_o.tx_done |=> !events_o.tx_done)
      else $error("tx event longer than a cycle");
   rx_excl_a: assert property (!(events_o.rx_done && events_o.rx_error))
      else $error("rx done and error together");
   reply_start_a: assert property ((events_o.rx_done || events_o.rx_error) && !busy_o |-> ##[1:8] !serial_out_line_o)
      else $error("reply did not start");
   busy_rx_a: assert property (events_o.rx_done |-> ##[0:2] busy_o)
      else $error("no busy after rx");
   stop_high_a: assert property (events_o.tx_done |-> serial_out_line_o)
      else $error("tx done off stop bit");
   err_class_a: assert property (events_o.rx_error |-> ##[0:1] last_err_o != '0)
      else $error("error event without class");
   low_limit_a: assert property (low_cnt <= 10 * BIT_CYC)
      else $error("tx low too long");
endmodule : ucr_chk
bind ucr_responder ucr_chk #(.BIT_CYC(BIT_CYC)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .serial_in_line_i(serial_in_line_i), .serial_out_line_o(serial_out_line_o), .events_o(events_o),
   .last_err_o(last_err_o), .busy_o(busy_o));

// ===== verif/ucr_term.sv
// ucr_term: remote terminal sending characters and collecting replies
// assumes clk_i shared with the responder; lines idle high
`timescale 1ns/1ps
module ucr_term #(
   parameter int unsigned BIT_CYC = 16 // cycles per bit
) (
   input wire logic clk_i, // clock
   input wire logic line_i, // reply line
   output logic line_o // character line
);
   logic [7:0] got[$];
   int frame_errs = 0;
   initial line_o = 1'b1;
   // =========================================
   // one frame: start, data lsb first, even parity, stop
   task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
      logic [10:0] f;
      f = {~bad_stop, (^b) ^ bad_par, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_o <= f[i];
         repeat (BIT_CYC) @(posedge clk_i);
      end
      line_o <= 1'b1;
      // one idle edge, so back-to-back calls never assign the line twice at once
      @(posedge clk_i);
   endtask : send
   // collects reply frames, sampling mid bit
   always begin : rx_side
      logic [10:0] f;
      @(negedge line_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 11; i++) begin
         if (i > 0) repeat (BIT_CYC) @(posedge clk_i);
         f[i] = line_i;
      end
      if (f[0] !== 1'b0 || f[10] !== 1'b1 || f[9] !== ^f[8:1]) frame_errs++;
      got.push_back(f[8:1]);
   end
endmodule : ucr_term

// ===== verif/test_uart_char_responder.sv
// test_uart_char_responder: characters in, four-byte replies checked
// assumes ucr_pkg, ucr_responder, ucr_term and ucr_chk compiled first
`timescale 1ns/1ps
module test_uart_char_responder;
   import ucr_pkg::*;
   localparam int unsigned BC = 16;
   typedef struct packed {logic [7:0] b; logic bp; logic bs; logic [15:0] e; logic [2:0] er;} ucr_row_t;
   ucr_row_t rows [6] = '{'{8'h54, 1'b0, 1'b0, 16'h4F4B, 3'h0}, '{8'h74, 1'b0, 1'b0, 16'h6F6B, 3'h0},
      '{8'h00, 1'b0, 1'b0, 16'h5543, 3'h0}, '{8'hFF, 1'b0, 1'b0, 16'h5543, 3'h0},
      '{8'h55, 1'b1, 1'b0, 16'h5045, 3'h4}, '{8'h54, 1'b0, 1'b1, 16'h4645, 3'h2}};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rx_line;
   logic tx_line;
   ucr_evt_t events;
   ucr_err_t last_err;
   logic busy;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int n_rxd = 0;
   int n_rxe = 0;
   int n_txd = 0;
   int base_rxd = 0;
   int base_rxe = 0;
   int base_txd = 0;
   // counts the one-cycle event pulses
   always @(posedge clk_i) begin
      if (events.rx_done === 1'b1) n_rxd++;
      if (events.rx_error === 1'b1) n_rxe++;
      if (events.tx_done === 1'b1) n_txd++;
   end
   // =========================================
   // clock, responder and remote terminal
   initial forever #5 clk_i = ~clk_i;
   ucr_responder #(.BIT_CYC(BC)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .serial_in_line_i(rx_line),
      .serial_out_line_o(tx_line), .events_o(events), .last_err_o(last_err), .busy_o(busy));
   ucr_term #(.BIT_CYC(BC)) term_u (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
   task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // waits for one reply and compares its bytes in order
   task take(input logic [15:0] e);
      logic [31:0] x;
      int w;
      x = {e, CH_CR, CH_LF};
      w = 0;
      while (term_u.got.size() < 4 && w < 80 * BC) begin
         @(posedge clk_i);
         w++;
      end
      for (int i = 3; i >= 0; i--) chk("reply byte", x[i*8+:8], term_u.got.size() > 0 ? term_u.got.pop_front() : 8'h00);
   endtask : take
   // after the last stop bit, compares events and error class since the previous call
   task evt_check(input int rxd, input int rxe, input int txd, input logic [2:0] er);
      repeat (BC) @(posedge clk_i);
      chk("rx done events", 8'(rxd), 8'(n_rxd - base_rxd));
      chk("rx error events", 8'(rxe), 8'(n_rxe - base_rxe));
      chk("tx done events", 8'(txd), 8'(n_txd - base_txd));
      chk("error class", {5'h00, er}, {5'h00, last_err});
      base_rxd = n_rxd;
      base_rxe = n_rxe;
      base_txd = n_txd;
   endtask : evt_check
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         term_u.send(rows[i].b, rows[i].bp, rows[i].bs);
         take(rows[i].e);
         evt_check(rows[i].er == 3'h0 ? 1 : 0, rows[i].er == 3'h0 ? 0 : 1, 4, rows[i].er);
         $display("test row %0d done", i);
      end
      term_u.send(CH_UP_T, 1'b0, 1'b0);
      term_u.send(CH_LO_T, 1'b0, 1'b0);
      take(16'h4F4B);
      take(16'h6F6B);
      evt_check(2, 0, 8, 3'h0);
      chk("frame errors", 8'h00, 8'(term_u.frame_errs));
      $display("test queued reply done");
      // a third character while a second reply is still owed
      term_u.send(CH_UP_T, 1'b0, 1'b0);
      term_u.send(CH_LO_T, 1'b0, 1'b0);
      term_u.send(8'h41, 1'b0, 1'b0);
      take(16'h4F4B);
      take(16'h4F45);
      evt_check(2, 1, 8, 3'h1);
      $display("test overrun done");
      term_u.send(CH_UP_T, 1'b0, 1'b0);
      repeat (3 * BC) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("tx line", 8'h01, {7'h00, tx_line});
      chk("busy", 8'h00, {7'h00, busy});
      repeat (12 * BC) @(posedge clk_i);
      term_u.got.delete();
      term_u.send(8'h41, 1'b0, 1'b0);
      take(16'h5543);
      evt_check(2, 0, 4, 3'h0);
      $display("test reset mid reply done");
      tally_and_finish();
   end
endmodule : test_uart_char_responder
